// ===== design/extp_ctrl.sv
// External port controller: access sequencer, pins and pending reads.
// Function
// - After SDRAM enable, block all SDRAM accesses for 100 microseconds.
// - In 16-bit host-bus mode, reads assert both byte selects.
// - Blocking reads and writes, any address, never change pending count.
// - Frame strobe pin driven only when frame output select is set.
// - Read and write strobe pins driven only when strobe select is set.
// - Ready wait limit counts interface clock cycles.
// - Ready input sampled on interface clock falling edge.
`timescale 1ns/1ns
module extp_ctrl #(
    parameter int HOLDOFF_CYCLES = extp_pkg::SDRAM_HOLDOFF_CYC,
    parameter int IFCLK_HALF = extp_pkg::IFCLK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Configuration
    input wire logic [1:0] mode,
    input wire logic sdram_enable,
    input wire logic frame_output_select,
    input wire logic strobe_output_select,
    input wire logic [extp_pkg::WAIT_W-1:0] ready_wait_limit,
    // Request from the on-chip masters
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_nonblocking,
    input wire logic [extp_pkg::ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_byte_en,
    input wire logic [extp_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    // Answer
    output logic rsp_valid,
    output logic [extp_pkg::DATA_W-1:0] rsp_rdata,
    output logic nb_done,
    output logic [extp_pkg::PEND_W-1:0] pending_nonblocking_read_counter,
    output logic sdram_holdoff,
    // Interface pins
    output logic interface_clock,
    output logic [extp_pkg::ADDR_W-1:0] addr_o,
    output logic [extp_pkg::DATA_W-1:0] data_o,
    output logic data_oe,
    input wire logic [extp_pkg::DATA_W-1:0] data_i,
    output logic [1:0] byte_sel_n,
    output logic frame_pin,
    output logic frame_pin_oe,
    output logic read_strobe_pin,
    output logic read_strobe_pin_oe,
    output logic write_strobe_pin,
    output logic write_strobe_pin_oe,
    input wire logic ready_input
);
    extp_wait_if wif ();

    extp_rdy_wait u_wait (
        .clk(clk),
        .sys_rst(sys_rst),
        .w(wif.wt)
    );

    // Pin inputs pass two flip-flops before any logic reads them.
    logic rdy_m;
    logic rdy_s;
    logic [extp_pkg::DATA_W-1:0] din_m;
    logic [extp_pkg::DATA_W-1:0] din_s;
    always_ff @(posedge clk) begin
        rdy_m <= ready_input;
        rdy_s <= rdy_m;
        din_m <= data_i;
        din_s <= din_m;
    end

    // Interface clock divider; edges are known one cycle ahead as pulses.
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic next_ifclk;
    logic div_term;
    logic rise_en;
    logic fall_en;
    always_comb begin
        div_term = (div_cnt == 8'(IFCLK_HALF - 1));
        rise_en = div_term && !interface_clock;
        fall_en = div_term && interface_clock;
        next_div_cnt = div_term ? 8'h00 : div_cnt + 8'h01;
        next_ifclk = div_term ? !interface_clock : interface_clock;
    end

    // SDRAM start-up hold-off.
    logic [extp_pkg::HOLDOFF_W-1:0] hold_cnt;
    logic [extp_pkg::HOLDOFF_W-1:0] next_hold_cnt;
    logic sden_q;
    logic blocked;
    always_comb begin
        next_hold_cnt = hold_cnt;
        if (sdram_enable && !sden_q) begin
            next_hold_cnt = extp_pkg::HOLDOFF_W'(HOLDOFF_CYCLES);
        end else if (hold_cnt != '0) begin
            next_hold_cnt = hold_cnt - 1'b1;
        end
        blocked = (mode == extp_pkg::EXTP_MODE_SDRAM) &&
                  (next_hold_cnt != '0 || !sdram_enable);
    end

    // Access sequencer.
    extp_pkg::extp_state_t state;
    extp_pkg::extp_state_t next_state;
    logic cur_write;
    logic cur_nb;
    logic next_cur_write;
    logic next_cur_nb;
    logic gp;
    logic take;
    logic nb_finish;
    logic pend_full;
    logic next_req_ready;
    logic next_rsp_valid;
    logic [extp_pkg::DATA_W-1:0] next_rsp_rdata;
    logic next_nb_done;
    logic [extp_pkg::PEND_W-1:0] next_pend;
    logic [extp_pkg::ADDR_W-1:0] next_addr_o;
    logic [extp_pkg::DATA_W-1:0] next_data_o;
    logic next_data_oe;
    logic [1:0] next_byte_sel_n;
    logic next_frame;
    logic next_rd;
    logic next_wr;
    logic next_frame_oe;
    logic next_strobe_oe;

    always_comb begin
        gp = (mode == extp_pkg::EXTP_MODE_GP);
        pend_full = (pending_nonblocking_read_counter == '1);
        take = req_valid && req_ready &&
               !(req_nonblocking && !req_write && pend_full);
        nb_finish = (state == extp_pkg::EXTP_ST_DONE) && cur_nb;
        next_state = state;
        next_cur_write = cur_write;
        next_cur_nb = cur_nb;
        next_addr_o = addr_o;
        next_data_o = data_o;
        next_data_oe = data_oe;
        next_byte_sel_n = byte_sel_n;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_nb_done = nb_finish;
        next_frame = frame_pin;
        next_rd = read_strobe_pin;
        next_wr = write_strobe_pin;
        case (state)
            extp_pkg::EXTP_ST_IDLE: begin
                if (take) begin
                    next_state = extp_pkg::EXTP_ST_ADDR;
                    next_cur_write = req_write;
                    next_cur_nb = req_nonblocking && !req_write;
                    next_addr_o = req_addr;
                    next_data_o = req_wdata;
                    next_data_oe = req_write;
                    next_byte_sel_n = ~req_byte_en;
                    if (!req_write && mode == extp_pkg::EXTP_MODE_HB16) begin
                        next_byte_sel_n = 2'h0;
                    end
                    next_frame = 1'b1;
                end
            end
            extp_pkg::EXTP_ST_ADDR: begin
                if (rise_en) begin
                    next_state = extp_pkg::EXTP_ST_DATA;
                    next_frame = 1'b0;
                    next_rd = !cur_write;
                    next_wr = cur_write;
                end
            end
            extp_pkg::EXTP_ST_DATA: begin
                // Outside general-purpose mode no ready stall applies.
                if (rise_en && (!gp || wif.proceed)) begin
                    next_state = extp_pkg::EXTP_ST_DONE;
                    next_rd = 1'b0;
                    next_wr = 1'b0;
                    next_rsp_rdata = cur_write ? rsp_rdata : din_s;
                end
            end
            extp_pkg::EXTP_ST_DONE: begin
                next_state = extp_pkg::EXTP_ST_IDLE;
                next_rsp_valid = 1'b1;
                next_data_oe = 1'b0;
                next_byte_sel_n = 2'h3;
            end
            default: begin
                next_state = extp_pkg::EXTP_ST_IDLE;
            end
        endcase
        // Only a started or finished non-blocking read moves the count,
        // so no address alias can disturb it.
        next_pend = pending_nonblocking_read_counter;
        if (take && req_nonblocking && !req_write) begin
            next_pend = pending_nonblocking_read_counter + 1'b1;
        end else if (nb_finish) begin
            next_pend = pending_nonblocking_read_counter - 1'b1;
        end
        next_req_ready = (next_state == extp_pkg::EXTP_ST_IDLE) && !blocked;
        next_frame_oe = gp && frame_output_select;
        next_strobe_oe = gp && strobe_output_select;
    end

    assign wif.active = (state == extp_pkg::EXTP_ST_DATA) && gp;
    assign wif.fall_en = fall_en;
    assign wif.rdy = rdy_s;
    assign wif.limit = ready_wait_limit;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_cnt <= 8'h00;
            interface_clock <= 1'b0;
            hold_cnt <= '0;
            sden_q <= 1'b0;
            sdram_holdoff <= 1'b0;
            state <= extp_pkg::EXTP_ST_IDLE;
            cur_write <= 1'b0;
            cur_nb <= 1'b0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            nb_done <= 1'b0;
            pending_nonblocking_read_counter <= '0;
            addr_o <= '0;
            data_o <= '0;
            data_oe <= 1'b0;
            byte_sel_n <= 2'h3;
            frame_pin <= 1'b0;
            read_strobe_pin <= 1'b0;
            write_strobe_pin <= 1'b0;
            frame_pin_oe <= 1'b0;
            read_strobe_pin_oe <= 1'b0;
            write_strobe_pin_oe <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            interface_clock <= next_ifclk;
            hold_cnt <= next_hold_cnt;
            sden_q <= sdram_enable;
            sdram_holdoff <= next_hold_cnt != '0;
            state <= next_state;
            cur_write <= next_cur_write;
            cur_nb <= next_cur_nb;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            nb_done <= next_nb_done;
            pending_nonblocking_read_counter <= next_pend;
            addr_o <= next_addr_o;
            data_o <= next_data_o;
            data_oe <= next_data_oe;
            byte_sel_n <= next_byte_sel_n;
            frame_pin <= next_frame;
            read_strobe_pin <= next_rd;
            write_strobe_pin <= next_wr;
            frame_pin_oe <= next_frame_oe;
            read_strobe_pin_oe <= next_strobe_oe;
            write_strobe_pin_oe <= next_strobe_oe;
        end
    end

    a_holdoff_blocks: assert property (@(posedge clk) disable iff (sys_rst)
        (sdram_holdoff && mode == extp_pkg::EXTP_MODE_SDRAM) |-> !req_ready)
        else $error("SDRAM access allowed during hold-off");
    a_holdoff_start: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(sdram_enable) |=> ##1 sdram_holdoff)
        else $error("hold-off not started by SDRAM enable");
    a_hb16_read_sel: assert property (@(posedge clk) disable iff (sys_rst)
        (state == extp_pkg::EXTP_ST_DATA && !cur_write &&
         mode == extp_pkg::EXTP_MODE_HB16) |-> byte_sel_n == 2'h0)
        else $error("host-bus read without both byte selects");
    a_pend_stable: assert property (@(posedge clk) disable iff (sys_rst)
        (!(take && req_nonblocking && !req_write) && !nb_finish)
        |=> $stable(pending_nonblocking_read_counter))
        else $error("pending read count moved without cause");
    a_nb_complete: assert property (@(posedge clk) disable iff (sys_rst)
        nb_finish |=> nb_done && rsp_valid &&
        pending_nonblocking_read_counter ==
        $past(pending_nonblocking_read_counter) - 1'b1)
        else $error("non-blocking completion not reported");
    a_frame_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !(gp && frame_output_select) |=> !frame_pin_oe)
        else $error("frame pin driven while deselected");
    a_strobe_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !(gp && strobe_output_select)
        |=> !read_strobe_pin_oe && !write_strobe_pin_oe)
        else $error("strobe pins driven while deselected");
    a_gp_stall: assert property (@(posedge clk) disable iff (sys_rst)
        (state == extp_pkg::EXTP_ST_DATA && gp && !wif.proceed)
        |=> state == extp_pkg::EXTP_ST_DATA)
        else $error("data phase left before ready wait ended");
endmodule

// ===== design/extp_pkg.sv
// Shared constants and types of the external port controller.
package extp_pkg;
    // Port operating modes.
    typedef enum logic [1:0] {
        EXTP_MODE_SDRAM = 2'b00,
        EXTP_MODE_HB16 = 2'b01,
        EXTP_MODE_GP = 2'b10,
        EXTP_MODE_OFF = 2'b11
    } extp_mode_t;

    // Access sequencer states.
    typedef enum logic [1:0] {
        EXTP_ST_IDLE = 2'b00,
        EXTP_ST_ADDR = 2'b01,
        EXTP_ST_DATA = 2'b10,
        EXTP_ST_DONE = 2'b11
    } extp_state_t;

    localparam int CLK_MHZ = 100;
    localparam int SDRAM_HOLDOFF_US = 100;
    localparam int SDRAM_HOLDOFF_CYC = SDRAM_HOLDOFF_US * CLK_MHZ;
    localparam int HOLDOFF_W = 16;
    localparam int IFCLK_HALF_CYC = 2;
    localparam int WAIT_W = 8;
    localparam int PEND_W = 3;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // Address bits [11:4] values that must never disturb the pending count.
    localparam logic [7:0] NB_ALIAS_A = 8'h07;
    localparam logic [7:0] NB_ALIAS_B = 8'h08;
endpackage

// ===== design/extp_wait_if.sv
// Link between the access sequencer and the ready wait timer.
`timescale 1ns/1ns
interface extp_wait_if;
    logic active;
    logic fall_en;
    logic rdy;
    logic [extp_pkg::WAIT_W-1:0] limit;
    logic proceed;

    modport seq (output active, output fall_en, output rdy,
                 output limit, input proceed);
    modport wt (input active, input fall_en, input rdy,
                input limit, output proceed);
endinterface

// ===== design/extp_rdy_wait.sv
// Ready wait timer counting interface clock cycles.
`timescale 1ns/1ns
module extp_rdy_wait (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sequencer link
    extp_wait_if.wt w
);
    logic [extp_pkg::WAIT_W-1:0] cnt;
    logic [extp_pkg::WAIT_W-1:0] next_cnt;
    logic proceed;
    logic next_proceed;

    // Ready is looked at only on interface clock falling edges, so the
    // wait limit is a count of interface clocks, not system clocks.
    always_comb begin
        next_cnt = cnt;
        next_proceed = proceed;
        if (!w.active) begin
            next_cnt = '0;
            next_proceed = 1'b0;
        end else if (w.fall_en && !proceed) begin
            if (!w.rdy || cnt >= w.limit) begin
                next_proceed = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= '0;
            proceed <= 1'b0;
        end else begin
            cnt <= next_cnt;
            proceed <= next_proceed;
        end
    end

    assign w.proceed = proceed;

    a_wait_bounded: assert property (@(posedge clk) disable iff (sys_rst)
        w.active |-> cnt <= w.limit)
        else $error("ready wait count passed its limit");
    a_wait_expire: assert property (@(posedge clk) disable iff (sys_rst)
        (w.active && w.fall_en && !proceed && cnt >= w.limit)
        |=> proceed)
        else $error("wait limit expired without proceeding");
    a_rdy_fall_only: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(proceed) |-> $past(w.fall_en))
        else $error("ready sampled off the interface falling edge");
endmodule

// ===== verif/extp_partner.sv
// Far-side model: a parallel device that answers reads and can stall.
`timescale 1ns/1ns
module extp_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pins from the controller
    input wire logic interface_clock,
    input wire logic [19:0] addr_o,
    input wire logic read_strobe_pin,
    input wire logic write_strobe_pin,
    // Stall length in interface clocks, zero for none
    input wire logic [3:0] stall_len,
    // Pins to the controller
    output logic [15:0] data_i = 16'h0000,
    output logic ready_input = 1'b0
);
    logic prev_ifclk = 1'b0;
    logic [3:0] cnt = 4'h0;
    always @(posedge clk) begin
        prev_ifclk <= interface_clock;
        // Released data lines toggle, so a stale capture cannot match.
        data_i <= read_strobe_pin ? (addr_o[15:0] ^ 16'h5A3C) : ~data_i;
        if (sys_rst || !(read_strobe_pin || write_strobe_pin)) begin
            cnt <= 4'h0;
            ready_input <= 1'b0;
        end else if (cnt == 4'h0 && !ready_input && stall_len != 4'h0) begin
            ready_input <= 1'b1;
        end else if (ready_input && interface_clock && !prev_ifclk) begin
            // While a strobe is high, ready only drops just after an interface rising edge.
            cnt <= cnt + 4'h1;
            if (cnt + 4'h1 == stall_len) begin
                ready_input <= 1'b0;
            end
        end
    end
endmodule

// ===== verif/external_port_controller_bench.sv
// Self-checking bench for the external port controller.
`timescale 1ns/1ns
module external_port_controller_bench;
    localparam int HOLD = 20;
    localparam int HALF = 8;
    localparam int IFP = 2 * HALF;
    localparam logic [15:0] PAT = 16'h5A3C;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] mode = 2'b00;
    logic sdram_enable = 1'b0;
    logic frm_sel = 1'b0;
    logic stb_sel = 1'b0;
    logic [7:0] limit = 8'h00;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_nb = 1'b0;
    logic [19:0] req_addr = 20'h00000;
    logic [1:0] req_be = 2'b00;
    logic [15:0] req_wdata = 16'h0000;
    logic [3:0] stall = 4'h0;
    logic req_ready, rsp_valid, nb_done, holdoff, ifclk, data_oe, rdy;
    logic frm, frm_oe, rds, rds_oe, wrs, wrs_oe;
    logic [15:0] rsp_rdata, data_o, data_i, wr_dat;
    logic [19:0] addr_o;
    logic [2:0] pend;
    logic [1:0] bs_n, rd_bs, wr_bs;
    int num_errors = 0;
    int total_checks = 0;
    int frm_seen = 0;
    int stb_seen = 0;
    int nb_cnt = 0;
    int pend_max = 0;
    int cyc = 0;
    int n, d0, d1, f;

    extp_ctrl #(.HOLDOFF_CYCLES(HOLD), .IFCLK_HALF(HALF)) uut (
        .clk(clk), .sys_rst(sys_rst), .mode(mode),
        .sdram_enable(sdram_enable), .frame_output_select(frm_sel),
        .strobe_output_select(stb_sel), .ready_wait_limit(limit),
        .req_valid(req_valid), .req_write(req_write),
        .req_nonblocking(req_nb), .req_addr(req_addr),
        .req_byte_en(req_be), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .nb_done(nb_done),
        .pending_nonblocking_read_counter(pend), .sdram_holdoff(holdoff),
        .interface_clock(ifclk), .addr_o(addr_o), .data_o(data_o),
        .data_oe(data_oe), .data_i(data_i), .byte_sel_n(bs_n),
        .frame_pin(frm), .frame_pin_oe(frm_oe), .read_strobe_pin(rds),
        .read_strobe_pin_oe(rds_oe), .write_strobe_pin(wrs),
        .write_strobe_pin_oe(wrs_oe), .ready_input(rdy));

    extp_partner dev (
        .clk(clk), .sys_rst(sys_rst), .interface_clock(ifclk),
        .addr_o(addr_o), .read_strobe_pin(rds), .write_strobe_pin(wrs),
        .stall_len(stall), .data_i(data_i), .ready_input(rdy));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        if (rds === 1'b1) rd_bs <= bs_n;
        if (wrs === 1'b1) wr_bs <= bs_n;
        if (wrs === 1'b1) wr_dat <= data_oe ? data_o : 16'h0000;
        // Count only cycles in which a strobe really reaches its pin.
        if (frm_oe === 1'b1 && frm === 1'b1) frm_seen <= frm_seen + 1;
        if ((rds_oe === 1'b1 && rds === 1'b1) ||
            (wrs_oe === 1'b1 && wrs === 1'b1)) stb_seen <= stb_seen + 1;
        if (nb_done === 1'b1) nb_cnt <= nb_cnt + 1;
        if (int'(pend) > pend_max) pend_max <= int'(pend);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            $display("Error timeout expected finish seen hang");
            results();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkr(input string what, input int lo, input int hi,
                        input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    // One whole access; the next one never starts before the answer.
    task automatic acc(input logic w, input logic nb, input logic [19:0] a,
                       input logic [1:0] be, output int dur);
        int k;
        k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_nb <= nb;
        req_addr <= a;
        req_be <= be;
        req_wdata <= ~a[15:0];
        do @(posedge clk); while (req_ready !== 1'b1 && ++k < 400);
        req_valid <= 1'b0;
        dur = 0;
        do begin
            @(posedge clk);
            dur++;
        end while (rsp_valid !== 1'b1 && dur < 400);
        // One more edge so the monitor counters hold this access's pulses.
        @(posedge clk);
        chkr("access cycles", 1, 399, dur);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("req_ready", 16'h0000, {15'h0000, req_ready});
        sdram_enable <= 1'b1;
        n = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && ++n < 400);
        chkr("holdoff cycles", HOLD - 1, HOLD + 6, n);
        chk("sdram_holdoff", 16'h0000, {15'h0000, holdoff});
        acc(1'b1, 1'b0, 20'h00010, 2'b11, d0);
        $display("test holdoff done");

        mode <= 2'b01;
        acc(1'b0, 1'b0, 20'h00123, 2'b01, d0);
        chk("read byte_sel_n", 16'h0000, {14'h0000, rd_bs});
        chk("rsp_rdata", 16'h0123 ^ PAT, rsp_rdata);
        acc(1'b1, 1'b0, 20'h00124, 2'b01, d0);
        chk("write byte_sel_n", 16'h0002, {14'h0000, wr_bs});
        chk("write data", 16'hFEDB, wr_dat);
        $display("test byte select done");

        acc(1'b0, 1'b1, 20'h00456, 2'b11, d0);
        chk("nb_done count", 16'h0001, 16'(nb_cnt));
        chk("pending peak", 16'h0001, 16'(pend_max));
        chk("rsp_rdata nb", 16'h0456 ^ PAT, rsp_rdata);
        for (int i = 0; i < 4; i++) begin
            acc(i[0], 1'b0, {8'h00, i[1] ? extp_pkg::NB_ALIAS_B :
                extp_pkg::NB_ALIAS_A, 4'h0}, 2'b11, d0);
            chk("pending count", 16'h0000, {13'h0000, pend});
        end
        chk("nb_done after alias", 16'h0001, 16'(nb_cnt));
        $display("test pending reads done");

        mode <= 2'b10;
        frm_sel <= 1'b1;
        limit <= 8'h0A;
        acc(1'b0, 1'b0, 20'h00200, 2'b11, d0);
        chk("frame oe seen", 16'h0001, {15'h0000, frm_seen != 0});
        chk("strobe oe seen", 16'h0000, 16'(stb_seen));
        f = frm_seen;
        frm_sel <= 1'b0;
        stb_sel <= 1'b1;
        acc(1'b1, 1'b0, 20'h00201, 2'b11, d1);
        chk("frame oe count", 16'(f), 16'(frm_seen));
        chk("strobe oe seen", 16'h0001, {15'h0000, stb_seen != 0});
        $display("test pin gating done");

        stall <= 4'h2;
        acc(1'b0, 1'b0, 20'h00202, 2'b11, d1);
        chkr("ready stall", d0 + 2 * IFP - 8, d0 + 2 * IFP + 8, d1);
        chk("stalled rdata", 16'h0202 ^ PAT, rsp_rdata);
        stall <= 4'hF;
        limit <= 8'h03;
        acc(1'b0, 1'b0, 20'h00203, 2'b11, d1);
        chkr("wait limit", d0 + 3 * IFP - 8, d0 + 3 * IFP + 8, d1);
        $display("test ready wait done");
        results();
    end
endmodule
